// *** verilog/cpl_pkg.sv ***
// cpl_pkg: shared constants and types of the colour palette lookup
package cpl_pkg;

    // widths and sizes
    localparam int IDX_W      = 8;
    localparam int COMP_W     = 6;
    localparam int DATA_W     = 8;
    localparam int ENTRY_W    = 18;
    localparam int ENTRIES    = 256;
    localparam int FIFO_DEPTH = 32;

    // reset values and steps
    localparam logic [IDX_W-1:0]  INDEX_RST   = 8'h00;
    localparam logic [IDX_W-1:0]  INDEX_LAST  = 8'hff;
    localparam logic [IDX_W-1:0]  INDEX_STEP  = 8'h01;
    localparam logic [IDX_W-1:0]  MASK_RST    = 8'hff;
    localparam logic [COMP_W-1:0] BLANK_LEVEL = 6'h00;

    // register select codes, written {reg_select_hi, reg_select_lo}
    localparam logic [1:0] SEL_IDX_WR = 2'h0;
    localparam logic [1:0] SEL_DATA   = 2'h1;
    localparam logic [1:0] SEL_MASK   = 2'h2;
    localparam logic [1:0] SEL_IDX_RD = 2'h3;

    // component phase, held in phase_q
    typedef enum logic [1:0] {
        PH_RED   = 2'b00,
        PH_GREEN = 2'b01,
        PH_BLUE  = 2'b10
    } cpl_phase_t;

    typedef struct packed {
        logic [COMP_W-1:0] red;
        logic [COMP_W-1:0] green;
        logic [COMP_W-1:0] blue;
    } cpl_color_t;

    typedef struct packed {
        logic             blank_n;
        logic [IDX_W-1:0] index;
    } cpl_pixel_t;

endpackage : cpl_pkg

// *** verilog/cpl_fifo.sv ***
// cpl_fifo: synchronous valid/ready fifo for the pixel stream
`timescale 1ns/1ns
module cpl_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clock_in,
    input  wire logic             srst_in,
    // filling side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // draining side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST  = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL  = CW'(DEPTH);
    localparam logic [CW-1:0] ONE   = CW'(1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [CW-1:0]    count_q;
    logic [CW-1:0]    count_d;
    logic             push;
    logic             pop;

    assign push    = in_valid_in & in_ready_out;
    assign pop     = out_valid_out & out_ready_in;
    assign count_d = push & ~pop ? count_q + ONE :
                     pop & ~push ? count_q - ONE : count_q;
    assign out_data_out = store[rd_ptr_q];

    always_ff @(posedge clock_in) begin
        if (push)
            store[wr_ptr_q] <= in_data_in;
    end

    // flags are registered so the ready seen by the source is glitch free
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            wr_ptr_q      <= '0;
            rd_ptr_q      <= '0;
            count_q       <= '0;
            in_ready_out  <= 1'b0;
            out_valid_out <= 1'b0;
        end else begin
            if (push)
                wr_ptr_q <= wr_ptr_q == LAST ? '0 : wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= rd_ptr_q == LAST ? '0 : rd_ptr_q + 1'b1;
            count_q       <= count_d;
            in_ready_out  <= count_d != FULL;
            out_valid_out <= count_d != '0;
        end
    end

    property p_full_stalls;
        @(posedge clock_in) disable iff (srst_in)
        count_q == FULL |-> !in_ready_out && out_valid_out;
    endproperty
    a_full_stalls: assert property (p_full_stalls)
        else $error("fifo full but still ready");

endmodule : cpl_fifo

// *** verilog/cpl_top.sv ***
// cpl_top: palette lookup with host register port and pixel lookup path
//
// Function
// - selects 00 index-write, 11 index-read, 01 palette data, 10 mask
// - index then red, green, blue writes; blue stores the 18-bit entry
// - index advances by one after each blue data write
// - red, green, blue reads return the entry; index advances after blue
// - components in bits 5..0; top bits ignored on write, zero on read
// - blue access at index ff wraps the index to 00
// - host port is independent of pixels; entry moves do not wait for pixel gaps
// - phase counter counts red, green, blue modulo three per data access
// - index write loads all bits and clears the phase; reads keep it
// - index read returns the index, changing neither index nor mode
// - pixel index captured when valid and ready, selects one of 256 entries
// - each entry gives six bits each of red, green and blue
// - blanking input travels with its pixel through the pipeline
// - pixel index is ANDed with the mask before lookup
// - mask readable and writable at any time without pixel disturbance
// - blanked pixels ignore the index and output the blanking level
// - write data captured when the write strobe rises
`timescale 1ns/1ns
module cpl_top #(
    parameter int FIFO_DEPTH = cpl_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       srst_in,
    // host register port
    input  wire logic       reg_select_lo_in,
    input  wire logic       reg_select_hi_in,
    input  wire logic       wr_n_in,
    input  wire logic       rd_n_in,
    input  wire logic [7:0] host_data_bus_in,
    output logic [7:0]      host_data_bus_out,
    output logic            host_data_bus_oe_out,
    // pixel stream from the frame buffer
    input  wire logic       pixel_valid_in,
    output logic            pixel_ready_out,
    input  wire logic [7:0] pixel_index_in,
    input  wire logic       blank_n_in,
    // colour words to the converters
    output logic            video_valid_out,
    input  wire logic       video_ready_in,
    output logic            blank_n_out,
    output logic [5:0]      red_out,
    output logic [5:0]      green_out,
    output logic [5:0]      blue_out
);
    localparam int IW = cpl_pkg::IDX_W;
    localparam int CW = cpl_pkg::COMP_W;
    localparam int DW = cpl_pkg::DATA_W;
    localparam int PW = $bits(cpl_pkg::cpl_pixel_t);

    function automatic cpl_pkg::cpl_phase_t next_phase(
        input cpl_pkg::cpl_phase_t ph
    );
        case (ph)
            cpl_pkg::PH_RED:   next_phase = cpl_pkg::PH_GREEN;
            cpl_pkg::PH_GREEN: next_phase = cpl_pkg::PH_BLUE;
            default:           next_phase = cpl_pkg::PH_RED;
        endcase
    endfunction : next_phase

    function automatic logic [DW-1:0] comp_byte(input logic [CW-1:0] c);
        comp_byte = {{(DW - CW){1'b0}}, c};
    endfunction : comp_byte

    // palette entries, two read ports and one write port
    cpl_pkg::cpl_color_t pal_mem [cpl_pkg::ENTRIES];

    // host side state
    logic [IW-1:0]       index_q;
    cpl_pkg::cpl_phase_t phase_q;
    logic                read_mode_q;
    logic [IW-1:0]       mask_q;
    cpl_pkg::cpl_color_t hold_q;
    logic                fetch_pend_q;
    logic                wr_prev_q;
    logic                rd_prev_q;
    logic [1:0]          rd_sel_q;

    // host side decode
    logic [1:0]          sel;
    logic                wr_done;
    logic                rd_start;
    logic                rd_end;
    logic                data_wr;
    logic                data_rd_end;
    logic                blue_step;
    logic                idx_load;
    logic [IW-1:0]       index_next;
    cpl_pkg::cpl_color_t host_word;
    logic [CW-1:0]       host_comp;
    logic [DW-1:0]       rd_byte;

    assign sel      = {reg_select_hi_in, reg_select_lo_in};
    // the strobes are sampled on clock_in; an edge is a change between samples
    assign wr_done  = wr_n_in & ~wr_prev_q & rd_n_in;
    // both strobes low is not a legal access and starts nothing
    assign rd_start = ~rd_n_in & rd_prev_q & wr_n_in;
    assign rd_end   = rd_n_in & ~rd_prev_q & host_data_bus_oe_out;
    assign data_wr  = wr_done & (sel == cpl_pkg::SEL_DATA);
    assign data_rd_end = rd_end & (rd_sel_q == cpl_pkg::SEL_DATA);
    assign blue_step = (data_wr | data_rd_end)
                     & (phase_q == cpl_pkg::PH_BLUE);
    assign idx_load = wr_done & (sel == cpl_pkg::SEL_IDX_WR
                               | sel == cpl_pkg::SEL_IDX_RD);
    // eight bit add rolls ff over to 00 by itself
    assign index_next = index_q + cpl_pkg::INDEX_STEP;

    // a pending fetch is served straight from memory, so a red read that
    // follows a blue read with no gap still sees the new entry
    assign host_word = fetch_pend_q ? pal_mem[index_q] : hold_q;
    assign host_comp = phase_q == cpl_pkg::PH_RED   ? host_word.red   :
                       phase_q == cpl_pkg::PH_GREEN ? host_word.green :
                                                      host_word.blue;
    assign rd_byte = sel == cpl_pkg::SEL_DATA ? comp_byte(host_comp) :
                     sel == cpl_pkg::SEL_MASK ? mask_q : index_q;

    // strobe history
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            wr_prev_q <= 1'b1;
            rd_prev_q <= 1'b1;
        end else begin
            wr_prev_q <= wr_n_in;
            rd_prev_q <= rd_n_in;
        end
    end

    // index and mode
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            index_q     <= cpl_pkg::INDEX_RST;
            read_mode_q <= 1'b0;
        end else if (idx_load) begin
            index_q     <= host_data_bus_in;
            read_mode_q <= sel == cpl_pkg::SEL_IDX_RD;
        end else if (blue_step) begin
            index_q     <= index_next;
        end
    end

    // component phase; index reads do not touch it
    always_ff @(posedge clock_in) begin
        if (srst_in)
            phase_q <= cpl_pkg::PH_RED;
        else if (idx_load)
            phase_q <= cpl_pkg::PH_RED;
        else if (data_wr)
            phase_q <= next_phase(phase_q);
        else if (data_rd_end)
            phase_q <= next_phase(phase_q);
    end

    // pixel mask, only ever changed by a host write
    always_ff @(posedge clock_in) begin
        if (srst_in)
            mask_q <= cpl_pkg::MASK_RST;
        else if (wr_done && sel == cpl_pkg::SEL_MASK)
            mask_q <= host_data_bus_in;
    end

    // fetch request: after an index load in read mode and after blue reads
    always_ff @(posedge clock_in) begin
        if (srst_in)
            fetch_pend_q <= 1'b0;
        else if (idx_load)
            fetch_pend_q <= sel == cpl_pkg::SEL_IDX_RD;
        else if (data_rd_end && phase_q == cpl_pkg::PH_BLUE)
            fetch_pend_q <= 1'b1;
        else
            fetch_pend_q <= 1'b0;
    end

    // holding registers: fetched entry or the components being assembled
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            hold_q <= '0;
        end else if (data_wr && phase_q == cpl_pkg::PH_RED) begin
            hold_q.red <= host_data_bus_in[CW-1:0];
        end else if (data_wr && phase_q == cpl_pkg::PH_GREEN) begin
            hold_q.green <= host_data_bus_in[CW-1:0];
        end else if (fetch_pend_q) begin
            hold_q <= pal_mem[index_q];
        end
    end

    // blue write concatenates the three components into one entry
    always_ff @(posedge clock_in) begin
        if (data_wr && phase_q == cpl_pkg::PH_BLUE)
            pal_mem[index_q] <= {hold_q.red, hold_q.green,
                                 host_data_bus_in[CW-1:0]};
    end

    // read data is frozen at the falling strobe and held until it rises
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            host_data_bus_out    <= '0;
            host_data_bus_oe_out <= 1'b0;
            rd_sel_q             <= cpl_pkg::SEL_IDX_WR;
        end else if (rd_start) begin
            host_data_bus_out    <= rd_byte;
            host_data_bus_oe_out <= 1'b1;
            rd_sel_q             <= sel;
        end else if (rd_n_in) begin
            host_data_bus_oe_out <= 1'b0;
        end
    end

    // pixel path
    cpl_pkg::cpl_pixel_t pix_in;
    cpl_pkg::cpl_pixel_t pix_head;
    logic [PW-1:0]       pix_head_bits;
    logic                pix_valid;
    logic                pix_pop;
    logic [IW-1:0]       masked_index;
    cpl_pkg::cpl_color_t lookup_word;
    cpl_pkg::cpl_color_t video_word;

    assign pix_in = '{blank_n: blank_n_in, index: pixel_index_in};
    assign pix_head = cpl_pkg::cpl_pixel_t'(pix_head_bits);
    // the downstream stage may stall; the fifo then fills and pushes back
    assign pix_pop = pix_valid & (~video_valid_out | video_ready_in);
    assign masked_index = pix_head.index & mask_q;
    assign lookup_word = pal_mem[masked_index];
    assign video_word = pix_head.blank_n ? lookup_word :
                        cpl_pkg::cpl_color_t'{red:   cpl_pkg::BLANK_LEVEL,
                                              green: cpl_pkg::BLANK_LEVEL,
                                              blue:  cpl_pkg::BLANK_LEVEL};

    cpl_fifo #(
        .WIDTH (PW),
        .DEPTH (FIFO_DEPTH)
    ) u_pixel_fifo (
        .clock_in      (clock_in),
        .srst_in       (srst_in),
        .in_valid_in   (pixel_valid_in),
        .in_ready_out  (pixel_ready_out),
        .in_data_in    (pix_in),
        .out_valid_out (pix_valid),
        .out_ready_in  (pix_pop),
        .out_data_out  (pix_head_bits)
    );

    // converter stage; host accesses never stall it
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            video_valid_out <= 1'b0;
            blank_n_out     <= 1'b0;
            red_out         <= cpl_pkg::BLANK_LEVEL;
            green_out       <= cpl_pkg::BLANK_LEVEL;
            blue_out        <= cpl_pkg::BLANK_LEVEL;
        end else if (pix_pop) begin
            video_valid_out <= 1'b1;
            blank_n_out     <= pix_head.blank_n;
            red_out         <= video_word.red;
            green_out       <= video_word.green;
            blue_out        <= video_word.blue;
        end else if (video_ready_in) begin
            video_valid_out <= 1'b0;
        end
    end

    property p_mask_write;
        @(posedge clock_in) disable iff (srst_in)
        wr_done && sel == cpl_pkg::SEL_MASK
        |=> mask_q == $past(host_data_bus_in) && $stable(index_q);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write not taken");

    property p_index_load;
        @(posedge clock_in) disable iff (srst_in)
        idx_load |=> index_q == $past(host_data_bus_in)
                     && phase_q == cpl_pkg::PH_RED;
    endproperty
    a_index_load: assert property (p_index_load)
        else $error("index load did not clear phase");

    property p_blue_write_step;
        @(posedge clock_in) disable iff (srst_in)
        data_wr && phase_q == cpl_pkg::PH_BLUE
        |=> index_q == $past(index_next) && phase_q == cpl_pkg::PH_RED;
    endproperty
    a_blue_write_step: assert property (p_blue_write_step)
        else $error("index did not advance after blue write");

    property p_wrap;
        @(posedge clock_in) disable iff (srst_in)
        blue_step && index_q == cpl_pkg::INDEX_LAST
        |=> index_q == cpl_pkg::INDEX_RST;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("index did not wrap to zero");

    property p_blue_read;
        @(posedge clock_in) disable iff (srst_in)
        data_rd_end && phase_q == cpl_pkg::PH_BLUE
        |=> fetch_pend_q && index_q == $past(index_next)
            ##1 !fetch_pend_q && hold_q == pal_mem[index_q];
    endproperty
    a_blue_read: assert property (p_blue_read)
        else $error("blue read did not advance and fetch");

    property p_index_read;
        @(posedge clock_in) disable iff (srst_in)
        rd_start && (sel == cpl_pkg::SEL_IDX_WR || sel == cpl_pkg::SEL_IDX_RD)
        |=> host_data_bus_oe_out && host_data_bus_out == $past(index_q)
            && $stable(index_q) && $stable(read_mode_q)
            && $stable(phase_q);
    endproperty
    a_index_read: assert property (p_index_read)
        else $error("index read disturbed state");

    property p_comp_upper;
        @(posedge clock_in) disable iff (srst_in)
        host_data_bus_oe_out && rd_sel_q == cpl_pkg::SEL_DATA
        |-> host_data_bus_out[DW-1:CW] == '0;
    endproperty
    a_comp_upper: assert property (p_comp_upper)
        else $error("component read upper bits not zero");

    property p_phase_legal;
        @(posedge clock_in) disable iff (srst_in)
        phase_q inside {cpl_pkg::PH_RED, cpl_pkg::PH_GREEN, cpl_pkg::PH_BLUE};
    endproperty
    a_phase_legal: assert property (p_phase_legal)
        else $error("phase counter left modulo three");

    property p_lookup;
        @(posedge clock_in) disable iff (srst_in)
        pix_pop && pix_head.blank_n
        |=> {red_out, green_out, blue_out} == $past(lookup_word)
            && blank_n_out && video_valid_out;
    endproperty
    a_lookup: assert property (p_lookup)
        else $error("masked lookup mismatch");

    property p_blank;
        @(posedge clock_in) disable iff (srst_in)
        pix_pop && !pix_head.blank_n
        |=> !blank_n_out && red_out == cpl_pkg::BLANK_LEVEL
            && green_out == cpl_pkg::BLANK_LEVEL
            && blue_out == cpl_pkg::BLANK_LEVEL;
    endproperty
    a_blank: assert property (p_blank)
        else $error("blanked pixel not at blank level");

    property p_video_hold;
        @(posedge clock_in) disable iff (srst_in)
        video_valid_out && !video_ready_in
        |=> video_valid_out && $stable({blank_n_out, red_out,
                                        green_out, blue_out});
    endproperty
    a_video_hold: assert property (p_video_hold)
        else $error("stalled colour word changed");

endmodule : cpl_top

// *** test/cpl_fb_model.sv ***
// cpl_fb_model: frame buffer pixel source and converter sink
`timescale 1ns/1ns
module cpl_fb_model (
    // clock
    input  wire logic       clock_in,
    // pixel source
    output logic            pixel_valid_out,
    input  wire logic       pixel_ready_in,
    output logic [7:0]      pixel_index_out,
    output logic            blank_n_out,
    // colour sink
    input  wire logic       video_valid_in,
    output logic            video_ready_out,
    input  wire logic       video_blank_n_in,
    input  wire logic [5:0] red_in,
    input  wire logic [5:0] green_in,
    input  wire logic [5:0] blue_in,
    input  wire logic       stall_in
);
    cpl_pkg::cpl_pixel_t src_q[$];
    logic [18:0]         got_q[$];
    logic                taken = 1'b0;
    logic [2:0]          cnt = 3'h0;

    initial begin
        pixel_valid_out = 1'b0;
        pixel_index_out = 8'h00;
        blank_n_out = 1'b1;
        video_ready_out = 1'b0;
    end

    // ready is registered, so its value here holds until the taking edge
    always @(negedge clock_in) begin
        if (taken) begin
            void'(src_q.pop_front());
        end
        if (src_q.size() > 0) begin
            pixel_valid_out = 1'b1;
            {blank_n_out, pixel_index_out} = src_q[0];
        end else begin
            // idle lines toggle so stale values never look valid
            pixel_valid_out = 1'b0;
            {blank_n_out, pixel_index_out} = ~{blank_n_out, pixel_index_out};
        end
        taken = pixel_valid_out && pixel_ready_in;
    end

    // stall lets one word in eight through, which backs up the fifo
    always @(negedge clock_in) begin
        cnt = cnt + 3'h1;
        video_ready_out = !stall_in || (cnt == 3'h0);
        if (video_valid_in && video_ready_out) begin
            got_q.push_back({video_blank_n_in, red_in, green_in, blue_in});
        end
    end
endmodule : cpl_fb_model

// *** test/tb_top.sv ***
// tb_top: self-checking bench of the colour palette lookup
`timescale 1ns/1ns
module tb_top;
    localparam int DEPTH = 4;
    logic        clk, srst, rs_lo, rs_hi, wr_n, rd_n, stall;
    logic [7:0]  dbus, dout, pidx, mask;
    logic        oe, pv, pr, vv, vr, bo, bi;
    logic [5:0]  r, g, b;
    int          fail_count = 0;
    int          comparisons = 0;
    logic [17:0] pal [256];
    logic [7:0]  wdat [12] = '{8'hd1, 8'he2, 8'hf3, 8'h7f, 8'h80, 8'h2a,
                              8'h45, 8'hbc, 8'h19, 8'h3c, 8'h03, 8'hc0};
    cpl_pkg::cpl_pixel_t pxs[$];

    cpl_top #(.FIFO_DEPTH(DEPTH)) uut (
        .clock_in(clk), .srst_in(srst),
        .reg_select_lo_in(rs_lo), .reg_select_hi_in(rs_hi),
        .wr_n_in(wr_n), .rd_n_in(rd_n), .host_data_bus_in(dbus),
        .host_data_bus_out(dout), .host_data_bus_oe_out(oe),
        .pixel_valid_in(pv), .pixel_ready_out(pr),
        .pixel_index_in(pidx), .blank_n_in(bi),
        .video_valid_out(vv), .video_ready_in(vr), .blank_n_out(bo),
        .red_out(r), .green_out(g), .blue_out(b));

    cpl_fb_model fb (
        .clock_in(clk), .pixel_valid_out(pv), .pixel_ready_in(pr),
        .pixel_index_out(pidx), .blank_n_out(bi), .video_valid_in(vv),
        .video_ready_out(vr), .video_blank_n_in(bo), .red_in(r),
        .green_in(g), .blue_in(b), .stall_in(stall));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // data stays put on the edge that sees the strobe return high
    task automatic host_wr(input logic [1:0] sel, input logic [7:0] d);
        @(negedge clk);
        {rs_hi, rs_lo} = sel;
        dbus = d;
        wr_n = 1'b0;
        @(negedge clk);
        wr_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask : host_wr

    task automatic host_rd(input logic [1:0] sel, output logic [7:0] d);
        @(negedge clk);
        {rs_hi, rs_lo} = sel;
        rd_n = 1'b0;
        repeat (2) @(negedge clk);
        d = oe ? dout : 8'hxx;
        rd_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask : host_rd

    function automatic logic [18:0] exp_word(cpl_pkg::cpl_pixel_t p);
        return p.blank_n ? {1'b1, pal[p.index & mask]} : 19'h0;
    endfunction : exp_word

    task automatic stream(input logic stl, output logic full);
        int n;
        n = pxs.size();
        full = 1'b0;
        @(negedge clk);
        stall = stl;
        fb.got_q.delete();
        foreach (pxs[i]) fb.src_q.push_back(pxs[i]);
        for (int c = 0; c < 600 && fb.got_q.size() < n; c++) begin
            @(negedge clk);
            if (!pr && fb.src_q.size() > 0) full = 1'b1;
        end
        check(fb.got_q.size(), n);
        foreach (pxs[i]) check(fb.got_q[i], exp_word(pxs[i]));
        stall = 1'b0;
        pxs.delete();
    endtask : stream

    task automatic t_reset;
        logic [7:0] d;
        host_rd(cpl_pkg::SEL_IDX_RD, d);
        check(d, cpl_pkg::INDEX_RST);
        host_rd(cpl_pkg::SEL_MASK, d);
        check(d, cpl_pkg::MASK_RST);
        $display("test reset done");
    endtask : t_reset

    // four entries from fe: the index wraps, and every entry that a later
    // blue read prefetches holds known data
    task automatic t_write;
        logic [7:0] d;
        host_wr(cpl_pkg::SEL_IDX_WR, 8'hfe);
        for (int i = 0; i < 12; i++) host_wr(cpl_pkg::SEL_DATA, wdat[i]);
        for (int e = 0; e < 4; e++) begin
            pal[8'(8'hfe + e)] = {wdat[3*e][5:0], wdat[3*e+1][5:0],
                                  wdat[3*e+2][5:0]};
        end
        host_rd(cpl_pkg::SEL_IDX_WR, d);
        check(d, 8'h02);
        $display("test write done");
    endtask : t_write

    task automatic t_read;
        logic [7:0] d;
        host_wr(cpl_pkg::SEL_IDX_RD, 8'hfe);
        for (int i = 0; i < 9; i++) begin
            host_rd(cpl_pkg::SEL_DATA, d);
            check(d, wdat[i] & 8'h3f);
            if (i == 0) begin
                host_rd(cpl_pkg::SEL_IDX_RD, d);
                check(d, 8'hfe);
            end
        end
        host_rd(cpl_pkg::SEL_IDX_RD, d);
        check(d, 8'h01);
        $display("test read done");
    endtask : t_read

    task automatic t_phase;
        logic [7:0] d;
        logic [7:0] pd [3] = '{8'h2a, 8'h15, 8'h3f};
        host_wr(cpl_pkg::SEL_IDX_WR, 8'h00);
        host_wr(cpl_pkg::SEL_DATA, 8'h01);
        host_wr(cpl_pkg::SEL_IDX_WR, 8'h00);
        for (int i = 0; i < 3; i++) host_wr(cpl_pkg::SEL_DATA, pd[i]);
        pal[0] = {pd[0][5:0], pd[1][5:0], pd[2][5:0]};
        host_wr(cpl_pkg::SEL_IDX_RD, 8'h00);
        for (int i = 0; i < 3; i++) begin
            host_rd(cpl_pkg::SEL_DATA, d);
            check(d, pd[i]);
        end
        $display("test phase done");
    endtask : t_phase

    task automatic t_pixels;
        logic [7:0] d;
        logic       full;
        host_wr(cpl_pkg::SEL_MASK, 8'hfe);
        host_rd(cpl_pkg::SEL_MASK, d);
        check(d, 8'hfe);
        mask = 8'hfe;
        pxs = '{'{1'b1, 8'hff}, '{1'b1, 8'h01}, '{1'b0, 8'h03},
                '{1'b1, 8'hfe}, '{1'b0, 8'hff}, '{1'b1, 8'h00}};
        stream(1'b0, full);
        $display("test pixels done");
    endtask : t_pixels

    task automatic t_full;
        logic full;
        host_wr(cpl_pkg::SEL_MASK, 8'hff);
        mask = 8'hff;
        for (int i = 0; i < 12; i++) pxs.push_back('{i[0], 8'(8'hfe + i % 3)});
        stream(1'b1, full);
        check(full, 1'b1);
        $display("test full done");
    endtask : t_full

    initial begin
        #(50 * 20000);
        fail_count++;
        final_report();
    end

    initial begin
        srst = 1'b1;
        {rs_hi, rs_lo} = 2'h0;
        wr_n = 1'b1;
        rd_n = 1'b1;
        dbus = 8'h00;
        stall = 1'b0;
        mask = cpl_pkg::MASK_RST;
        repeat (8) @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_write();
        t_read();
        t_phase();
        t_pixels();
        t_full();
        final_report();
    end
endmodule : tb_top
